// [core/ixp_defines.svh]
`ifndef IXP_DEFINES_SVH
`define IXP_DEFINES_SVH
// Summary of operation
// RULE_01: Pick shortest rotation direction to target station.
// RULE_02: Host sets both mode selects for mode 2.
// RULE_03: Position only when operation type leads with one.
// RULE_04: Eight select bits give station 0 to 254.
// RULE_05: Warn when station exceeds station count minus one.
// RULE_06: Ignore station numbering direction parameter here.
// RULE_07: Eight table entries: speed, acceleration, deceleration.
// RULE_08: Three speed bits select entry value plus one.
// RULE_09: One occupied station always uses entry one.
// RULE_10: Start during movement ignored; host waits complete.
// RULE_11: Start before home return raises home alarm.
// RULE_12: Speed selection latched only at start.
// RULE_13: Host sets selects before start for delay.
// RULE_14: Holding torque limit after in-position plus delay.
// RULE_15: Power-up in-position when already within range.
// RULE_16: Direct speed uses entry one acceleration times.
// RULE_17: Target station latched at start until complete.

`define IXP_ADR_CTRL     8'h00
`define IXP_ADR_STATION  8'h04
`define IXP_ADR_SPEEDSEL 8'h08
`define IXP_ADR_CFG      8'h0C
`define IXP_ADR_HOLDTRQ  8'h10
`define IXP_ADR_TRQDLY   8'h14
`define IXP_ADR_RUNTRQ   8'h18
`define IXP_ADR_STATUS   8'h1C
`define IXP_ADR_IRQSTAT  8'h20
`define IXP_ADR_IRQMASK  8'h24
`define IXP_ADR_DIRSPD   8'h28

`define IXP_CTRL_MODE0   0
`define IXP_CTRL_MODE1   1
`define IXP_CTRL_START   2
`define IXP_CTRL_ONESTN  3
`define IXP_CTRL_DIRSPD  4

`define IXP_CFG_OPTYPE_LSB 0
`define IXP_CFG_STNDIR     8
`define IXP_CFG_COUNT_LSB  16
`define IXP_OPTYPE_INDEXER 4'h1

`define IXP_IRQ_DONE  0
`define IXP_IRQ_HOME  1
`define IXP_IRQ_RANGE 2
`define IXP_IRQ_IGN   3

`define IXP_CFG_RESET    32'h0000_0000
`define IXP_TRQ_RESET    16'hFFFF

`define IXP_TICK_NS      1000000
`define IXP_CLK_NS       10
`define IXP_TICK_CYCLES  (`IXP_TICK_NS / `IXP_CLK_NS)
`endif

// [core/ixp_indexer.sv]
`timescale 1ns/100ps
`include "ixp_defines.svh"
module ixp_indexer #(
    parameter int TICK_CYCLES = `IXP_TICK_CYCLES
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                home_return_done,
    input  wire logic [7:0]          station_now,
    input  wire logic                station_in_range,
    input  wire logic                motion_done,
    output ixp_pkg::ixp_move_type    move_cmd,
    output logic                     move_start,
    output logic                     in_position,
    output logic                     movement_complete,
    output logic                     home_return_incomplete_alarm,
    output logic                     station_range_warning,
    output logic [15:0]              torque_limit,
    output logic                     irq
);
    import ixp_pkg::*;

    logic [4:0]          ctrl_q;
    logic [7:0]          station_sel_q;
    logic [2:0]          speed_sel_q;
    logic [31:0]         cfg_q;
    logic [15:0]         hold_trq_q;
    logic [15:0]         trq_dly_q;
    logic [15:0]         run_trq_q;
    logic [15:0]         dir_speed_q;
    ixp_point_type       table_q [0:7];
    logic [3:0]          irq_stat_q;
    logic [3:0]          irq_mask_q;
    logic                wait_q;
    logic [31:0]         rdata_q;
    ixp_state_type       state_q;
    logic                start_prev_q;
    logic                init_q;
    logic                hold_q;
    logic [16:0]         tick_cnt_q;
    logic [15:0]         dly_cnt_q;
    ixp_move_type        move_q;
    logic                move_start_q;
    logic                inpos_q;
    logic                mcomp_q;
    logic                alarm_q;
    logic                warn_q;
    logic [15:0]         trq_q;
    logic                irq_q;

    // Bus decode: one wait cycle, then the access completes.
    wire         req      = avs_read | avs_write;
    wire         done     = req & ~wait_q;
    wire         wr       = avs_write & done;
    wire         rd_done  = avs_read & done;
    wire         tbl_hit  = avs_address[7];
    wire [2:0]   tbl_idx  = avs_address[6:4];
    wire [1:0]   tbl_fld  = avs_address[3:2];
    wire         wr_reg   = wr & ~tbl_hit;
    wire         wr_tbl   = wr & tbl_hit;

    wire [3:0]   op_type  = cfg_q[`IXP_CFG_OPTYPE_LSB +: 4];
    wire [7:0]   stn_cnt  = cfg_q[`IXP_CFG_COUNT_LSB +: 8];

    wire [31:0] status_w = {12'h000, move_q.forward, speed_sel_q,
                            move_q.station, 2'h0, hold_q,
                            state_q == IXP_MOVE, alarm_q, warn_q,
                            mcomp_q, inpos_q};

    ixp_point_type tbl_rd;
    assign tbl_rd = table_q[tbl_idx];

    wire [15:0] tbl_word = (tbl_fld == 2'h0) ? tbl_rd.speed :
                           (tbl_fld == 2'h1) ? tbl_rd.accel :
                           (tbl_fld == 2'h2) ? tbl_rd.decel : 16'h0000;

    wire [31:0] reg_word =
        (avs_address == `IXP_ADR_CTRL)     ? {27'h0, ctrl_q}        :
        (avs_address == `IXP_ADR_STATION)  ? {24'h0, station_sel_q} :
        (avs_address == `IXP_ADR_SPEEDSEL) ? {29'h0, speed_sel_q}   :
        (avs_address == `IXP_ADR_CFG)      ? cfg_q                  :
        (avs_address == `IXP_ADR_HOLDTRQ)  ? {16'h0, hold_trq_q}    :
        (avs_address == `IXP_ADR_TRQDLY)   ? {16'h0, trq_dly_q}     :
        (avs_address == `IXP_ADR_RUNTRQ)   ? {16'h0, run_trq_q}     :
        (avs_address == `IXP_ADR_STATUS)   ? status_w               :
        (avs_address == `IXP_ADR_IRQSTAT)  ? {28'h0, irq_stat_q}    :
        (avs_address == `IXP_ADR_IRQMASK)  ? {28'h0, irq_mask_q}    :
        (avs_address == `IXP_ADR_DIRSPD)   ? {16'h0, dir_speed_q}   :
        32'h0000_0000;

    wire [31:0] rdata_d = tbl_hit ? {16'h0, tbl_word} : reg_word;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wait_q <= ~(req & wait_q);
            if (req & wait_q)
                rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_q        <= 5'h00;
            station_sel_q <= 8'h00;
            speed_sel_q   <= 3'h0;
            cfg_q         <= `IXP_CFG_RESET;
            hold_trq_q    <= `IXP_TRQ_RESET;
            trq_dly_q     <= 16'h0000;
            run_trq_q     <= `IXP_TRQ_RESET;
            dir_speed_q   <= 16'h0000;
            irq_mask_q    <= 4'h0;
        end
        else if (wr_reg)
        begin
            case (avs_address)
                `IXP_ADR_CTRL:     ctrl_q        <= avs_writedata[4:0];
                `IXP_ADR_STATION:  station_sel_q <= avs_writedata[7:0];
                `IXP_ADR_SPEEDSEL: speed_sel_q   <= avs_writedata[2:0];
                `IXP_ADR_CFG:      cfg_q         <= avs_writedata;
                `IXP_ADR_HOLDTRQ:  hold_trq_q    <= avs_writedata[15:0];
                `IXP_ADR_TRQDLY:   trq_dly_q     <= avs_writedata[15:0];
                `IXP_ADR_RUNTRQ:   run_trq_q     <= avs_writedata[15:0];
                `IXP_ADR_IRQMASK:  irq_mask_q    <= avs_writedata[3:0];
                `IXP_ADR_DIRSPD:   dir_speed_q   <= avs_writedata[15:0];
                default:           ctrl_q        <= ctrl_q;
            endcase
        end
    end

    // Point table holds no reset; software loads it before use.
    always_ff @(posedge clk_sys)
    begin
        if (wr_tbl && tbl_fld == 2'h0)
            table_q[tbl_idx].speed <= avs_writedata[15:0]; // RULE_07
        if (wr_tbl && tbl_fld == 2'h1)
            table_q[tbl_idx].accel <= avs_writedata[15:0]; // RULE_07
        if (wr_tbl && tbl_fld == 2'h2)
            table_q[tbl_idx].decel <= avs_writedata[15:0]; // RULE_07
    end

    // Start handling.
    wire start_rise = ctrl_q[`IXP_CTRL_START] & ~start_prev_q;
    wire mode_ok    = ctrl_q[`IXP_CTRL_MODE0] & ctrl_q[`IXP_CTRL_MODE1]
                      & (op_type == `IXP_OPTYPE_INDEXER); // RULE_03
    wire idle       = state_q == IXP_IDLE;
    wire take       = start_rise & mode_ok & idle; // RULE_10
    wire ignored    = start_rise & mode_ok & ~idle; // RULE_10
    wire home_bad   = take & ~home_return_done; // RULE_11
    wire [7:0] cnt_m1 = stn_cnt - 8'h01;
    wire range_bad  = (stn_cnt == 8'h00)
                      | (station_sel_q > cnt_m1); // RULE_05
    wire range_ev   = take & home_return_done & range_bad; // RULE_05
    wire go         = take & home_return_done & ~range_bad;

    // The numbering direction bit in cfg_q is never read here.
    wire [8:0] tgt9 = {1'b0, station_sel_q}; // RULE_04 RULE_06
    wire [8:0] cur9 = {1'b0, station_now};
    wire [8:0] fwd_dist = (tgt9 >= cur9) ? tgt9 - cur9
                          : tgt9 + {1'b0, stn_cnt} - cur9;
    wire fwd_short = {fwd_dist, 1'b0} <= {2'b00, stn_cnt}; // RULE_01

    wire [2:0] entry = ctrl_q[`IXP_CTRL_ONESTN] ? 3'h0
                       : speed_sel_q; // RULE_08 RULE_09
    wire use_direct = ctrl_q[`IXP_CTRL_DIRSPD]
                      & ~ctrl_q[`IXP_CTRL_ONESTN];
    ixp_point_type ent_w;
    ixp_point_type ent1_w;
    assign ent_w  = table_q[entry];
    assign ent1_w = table_q[0];

    ixp_move_type move_d;
    assign move_d.forward = fwd_short; // RULE_01
    assign move_d.station = station_sel_q; // RULE_17
    assign move_d.speed   = use_direct ? dir_speed_q
                            : ent_w.speed; // RULE_16
    assign move_d.accel   = use_direct ? ent1_w.accel
                            : ent_w.accel; // RULE_16
    assign move_d.decel   = use_direct ? ent1_w.decel
                            : ent_w.decel; // RULE_16

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q      <= IXP_IDLE;
            start_prev_q <= 1'b0;
            move_q       <= '0;
            move_start_q <= 1'b0;
        end
        else
        begin
            start_prev_q <= ctrl_q[`IXP_CTRL_START];
            move_start_q <= go;
            case (state_q)
                IXP_IDLE:
                    if (go)
                    begin
                        state_q <= IXP_MOVE;
                        move_q  <= move_d; // RULE_12 RULE_17
                    end
                IXP_MOVE:
                    if (motion_done)
                        state_q <= IXP_IDLE;
                default:
                    state_q <= IXP_IDLE;
            endcase
        end
    end

    wire arrive = (state_q == IXP_MOVE) & motion_done;

    // Output flags; alarm and warning sets win over clears, but go clears inpos_q and mcomp_q ahead of arrive.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            init_q  <= 1'b1;
            inpos_q <= 1'b0;
            mcomp_q <= 1'b0;
            alarm_q <= 1'b0;
            warn_q  <= 1'b0;
        end
        else
        begin
            init_q <= 1'b0;
            if (init_q)
            begin
                inpos_q <= station_in_range; // RULE_15
                mcomp_q <= 1'b1;
            end
            else if (go)
            begin
                inpos_q <= 1'b0;
                mcomp_q <= 1'b0;
            end
            else if (arrive)
            begin
                inpos_q <= 1'b1;
                mcomp_q <= 1'b1;
            end
            if (home_bad)
                alarm_q <= 1'b1; // RULE_11
            else if (home_return_done)
                alarm_q <= 1'b0;
            if (range_ev)
                warn_q <= 1'b1; // RULE_05
            else if (go)
                warn_q <= 1'b0;
        end
    end

    // Millisecond tick drives the holding torque delay.
    wire tick = tick_cnt_q == 17'(TICK_CYCLES - 1);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tick_cnt_q <= 17'h00000;
            dly_cnt_q  <= 16'h0000;
            hold_q     <= 1'b0;
            trq_q      <= `IXP_TRQ_RESET;
        end
        else
        begin
            tick_cnt_q <= tick ? 17'h00000 : tick_cnt_q + 17'h00001;
            if (!inpos_q)
            begin
                dly_cnt_q <= 16'h0000;
                hold_q    <= 1'b0;
            end
            else if (dly_cnt_q >= trq_dly_q)
                hold_q <= 1'b1; // RULE_14
            else if (tick)
                dly_cnt_q <= dly_cnt_q + 16'h0001;
            trq_q <= hold_q ? hold_trq_q : run_trq_q; // RULE_14
        end
    end

    // Interrupt status clears on a completed read; events win.
    wire [3:0] irq_ev  = {ignored, range_ev, home_bad, arrive};
    wire       irq_rd  = rd_done & ~tbl_hit
                         & (avs_address == `IXP_ADR_IRQSTAT);
    // Only the bits already returned to software are cleared.
    wire [3:0] irq_clr = irq_rd ? rdata_q[3:0] : 4'h0;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irq_stat_q <= 4'h0;
            irq_q      <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign avs_readdata                 = rdata_q;
    assign avs_waitrequest              = wait_q;
    assign move_cmd                     = move_q;
    assign move_start                   = move_start_q;
    assign in_position                  = inpos_q;
    assign movement_complete            = mcomp_q;
    assign home_return_incomplete_alarm = alarm_q;
    assign station_range_warning        = warn_q;
    assign torque_limit                 = trq_q;
    assign irq                          = irq_q;
endmodule

// [core/ixp_pkg.sv]
package ixp_pkg;
    typedef struct packed {
        logic [15:0] speed;
        logic [15:0] accel;
        logic [15:0] decel;
    } ixp_point_type;

    typedef struct packed {
        logic        forward;
        logic [7:0]  station;
        logic [15:0] speed;
        logic [15:0] accel;
        logic [15:0] decel;
    } ixp_move_type;

    typedef enum logic {
        IXP_IDLE,
        IXP_MOVE
    } ixp_state_type;
endpackage

// [verification/ixp_indexer_asserts.sv]
`timescale 1ns/100ps
module ixp_indexer_checker
    import ixp_pkg::*;
(
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic                   avs_waitrequest,
    input wire logic                   home_return_done,
    input wire logic                   motion_done,
    input wire ixp_pkg::ixp_move_type  move_cmd,
    input wire logic                   move_start,
    input wire logic                   in_position,
    input wire logic                   movement_complete
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_bus_answer_late: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus answer did not come one cycle after the request.");
    a_bus_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Wait request stayed low for more than one cycle.");
    a_start_drops_done: assert property (
        move_start |-> !movement_complete && !in_position)
        else $error("Launch did not drop completion and in-position.");
    a_start_from_idle: assert property (
        move_start |-> $past(movement_complete))
        else $error("Move launched while another was running.");
    a_busy_start_ignored: assert property (
        !movement_complete && !$past(movement_complete) |-> !move_start)
        else $error("Start taken during a running move.");
    a_home_gate_move: assert property (
        !home_return_done && !$past(home_return_done) |-> !move_start)
        else $error("Move launched without a home return.");
    a_done_after_motion: assert property (
        motion_done && !movement_complete |=> movement_complete)
        else $error("Completion did not follow the motor one cycle later.");
    a_target_held_move: assert property (
        !movement_complete && !move_start |-> $stable(move_cmd))
        else $error("Move command changed during a running move.");
endmodule

bind ixp_indexer ixp_indexer_checker u_chk (
    .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .home_return_done(home_return_done), .motion_done(motion_done),
    .move_cmd(move_cmd), .move_start(move_start),
    .in_position(in_position), .movement_complete(movement_complete));

// [verification/ixp_motor_model.sv]
`timescale 1ns/100ps
module ixp_motor_model
    import ixp_pkg::*;
(
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic                   move_start,
    input wire ixp_pkg::ixp_move_type  move_cmd,
    input wire logic [7:0]             lag,
    output logic [7:0]                 station_now,
    output logic                       station_in_range,
    output logic                       motion_done
);
    logic [7:0] left_q;
    logic       busy_q;
    // The motor reports arrival as a one-cycle pulse after a chosen lag.
    always_ff @(posedge clk_sys)
    begin
        motion_done <= 1'b0;
        if (rst)
        begin
            busy_q           <= 1'b0;
            station_now      <= 8'h00;
            station_in_range <= 1'b1;
        end
        else if (move_start)
        begin
            busy_q           <= 1'b1;
            left_q           <= lag;
            station_in_range <= 1'b0;
        end
        else if (busy_q && left_q == 8'h00)
        begin
            busy_q           <= 1'b0;
            motion_done      <= 1'b1;
            station_in_range <= 1'b1;
            station_now      <= move_cmd.station;
        end
        else if (busy_q)
            left_q <= left_q - 8'h01;
    end
endmodule

// [verification/tb_indexer_station_positioning.sv]
`timescale 1ns/100ps
module tb_indexer_station_positioning;
    import ixp_pkg::*;
    localparam int TK = 4;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, irq;
    logic home_return_done, station_in_range, motion_done, move_start;
    logic in_position, movement_complete;
    logic home_return_incomplete_alarm, station_range_warning;
    logic [7:0] avs_address, station_now, lag;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] torque_limit, hold, run;
    logic [15:0] tbl [8][3];
    ixp_move_type move_cmd;
    int failures, check_count;

    ixp_indexer #(.TICK_CYCLES(TK)) uut (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .home_return_done(home_return_done), .station_now(station_now),
        .station_in_range(station_in_range), .motion_done(motion_done),
        .move_cmd(move_cmd), .move_start(move_start),
        .in_position(in_position), .movement_complete(movement_complete),
        .home_return_incomplete_alarm(home_return_incomplete_alarm),
        .station_range_warning(station_range_warning),
        .torque_limit(torque_limit), .irq(irq));
    ixp_motor_model motor (
        .clk_sys(clk_sys), .rst(rst), .move_start(move_start),
        .move_cmd(move_cmd), .lag(lag), .station_now(station_now),
        .station_in_range(station_in_range), .motion_done(motion_done));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick(inout int n);
        @(posedge clk_sys);
        n++;
    endtask

    // Holds the request until wait request is seen low, then releases it.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        tick(n);
        while (avs_waitrequest !== 1'b0 && n < 40) tick(n);
        if (n >= 40) failures++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask

    function automatic logic fwd(input int now, input int stn);
        int d;
        d = (stn - now + 8) % 8;
        return d * 2 <= 8;
    endfunction

    task automatic mv(input int stn, sel, one, ok, mid, dsp);
        ixp_move_type e;
        int n;
        int ent;
        int dm;
        dm = (dsp != 0) ? 16 : 0;
        ent = (one != 0 || dm != 0) ? 0 : sel;
        e = {fwd(station_now, stn), 8'(stn), tbl[ent][0], tbl[ent][1],
             tbl[ent][2]};
        if (dm != 0)
            e.speed = 16'(dsp);
        bus(1'b1, 8'h04, 32'(stn));
        bus(1'b1, 8'h08, 32'(sel));
        bus(1'b1, 8'h28, 32'(dsp));
        bus(1'b1, 8'h00, 32'(3 + 8 * one + dm));
        bus(1'b1, 8'h00, 32'(7 + 8 * one + dm));
        n = 0;
        while (move_start !== 1'b1 && n < 6) tick(n);
        check(move_start, 64'(ok));
        if (ok)
        begin
            check(move_cmd, e);
            check(move_cmd[47:0], e[47:0]);
            if (mid)
            begin
                bus(1'b1, 8'h04, 32'(stn ^ 1));
                bus(1'b1, 8'h08, 32'(sel ^ 7));
                bus(1'b1, 8'h00, 32'h3);
                bus(1'b1, 8'h00, 32'h7);
            end
            n = 0;
            while (movement_complete !== 1'b1 && n < 400) tick(n);
            check(move_cmd, e);
            check(in_position, 64'h1);
            check(torque_limit, run);
            repeat (3 * TK + 3) @(posedge clk_sys);
            check(torque_limit, hold);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(32'hB0D2DFDA));
        {avs_read, avs_write, home_return_done} = 3'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        lag = 8'h03;
        rst = 1'b1;
        failures = 0;
        check_count = 0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(in_position, 64'h1);
        check(movement_complete, 64'h1);
        for (int e = 0; e < 24; e++)
        begin
            tbl[e / 3][e % 3] = 16'($urandom);
            bus(1'b1, 8'(8'h80 + (e / 3) * 16 + (e % 3) * 4),
                32'(tbl[e / 3][e % 3]));
        end
        hold = 16'($urandom);
        run = ~hold;
        bus(1'b1, 8'h10, 32'(hold));
        bus(1'b1, 8'h14, 32'h2);
        bus(1'b1, 8'h18, 32'(run));
        bus(1'b0, 8'h7C, 32'h0);
        check(rd, 64'h0);
        bus(1'b1, 8'h0C, 32'h0008_0002);
        bus(1'b1, 8'h24, 32'h8);
        home_return_done <= 1'b1;
        mv(2, 0, 0, 0, 0, 0);
        home_return_done <= 1'b0;
        bus(1'b1, 8'h0C, 32'h0008_0001);
        mv(1, 0, 0, 0, 0, 0);
        check(home_return_incomplete_alarm, 64'h1);
        home_return_done <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(home_return_incomplete_alarm, 64'h0);
        mv(8, 0, 0, 0, 0, 0);
        check(station_range_warning, 64'h1);
        mv(7, 1, 0, 1, 0, 0);
        check(station_range_warning, 64'h0);
        bus(1'b0, 8'h1C, 32'h0);
        check(rd, 64'h0001_0723);
        for (int i = 0; i < 9; i++)
        begin
            lag <= 8'($urandom % 20);
            bus(1'b1, 8'h0C, 32'h0008_0001 | 32'(i % 2) << 8);
            mv($urandom % 8, (i + 3) % 8, i == 8, 1, 0, 0);
        end
        mv(3, 5, 0, 1, 0, 32'h1 + $urandom % 32'hFFFF);
        check(irq, 64'h0);
        lag <= 8'h28;
        mv(5, 2, 0, 1, 1, 0);
        check(irq, 64'h1);
        bus(1'b0, 8'h20, 32'h0);
        check(rd[3], 64'h1);
        repeat (2) @(posedge clk_sys);
        check(irq, 64'h0);
        give_verdict();
    end
endmodule
